/* inc/dpr_cfg.svh */
// Timing constants and pin widths for the dual-port RAM port controller
// Operation
// [R1] Write happens during chip select and write overlap
// [R2] Select RAM or semaphore, hold through write
// [R3] Late select after write keeps outputs off
// [R4] With output enable low, lengthen write pulse
// [R5] Change address only with write inactive
// [R6] Never drive data while device drives pins
// [R7] Semaphore read shows flag on all lines
// [R8] Contended semaphore release grants exactly one side
// [R9] Earlier port by setup time wins conflict
// [R10] Close arrivals give busy to one port
// [R11] Busy asserts and releases within 10 ns
// [R12] Busy delay only for opposite-port write
// [R13] Read data valid after last access delay
// [R14] Outputs follow last enable on, first off
// [R15] Busy blocks the port's write until high
// [R16] Hold write 8 ns after busy releases
// [R17] Slave busy input inhibits write from start
// [R18] Written data reaches far port within 22 ns
// [R19] Device ignores writes while driving busy low
// [R20] Conflict only with both selects and match
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
`define DPR_CLK_PS 5000
`define DPR_ADDR_W 17
`define DPR_DATA_W 36
`define DPR_BE_W 4
`define DPR_WP_PS 8000
`define DPR_WZ_PS 4000
`define DPR_DW_PS 6000
`define DPR_WP_CYC (((`DPR_WP_PS) + (`DPR_CLK_PS) - 1) / (`DPR_CLK_PS))
`define DPR_WZDW_CYC (((`DPR_WZ_PS) + (`DPR_DW_PS) + (`DPR_CLK_PS) - 1) / (`DPR_CLK_PS))
`define DPR_WH_PS 8000
`define DPR_WH_CYC (((`DPR_WH_PS) + (`DPR_CLK_PS) - 1) / (`DPR_CLK_PS))
`define DPR_RD_PS 22000
`define DPR_RD_CYC (((`DPR_RD_PS) + (`DPR_CLK_PS) - 1) / (`DPR_CLK_PS))
`define DPR_HZ_PS 4000
`define DPR_HZ_CYC (((`DPR_HZ_PS) + (`DPR_CLK_PS) - 1) / (`DPR_CLK_PS))
`define DPR_CNT_W 4
`endif

/* inc/dpr_pkg.sv */
// Types shared by the dual-port RAM port controller
`include "dpr_cfg.svh"
package dpr_pkg;
  typedef enum logic [1:0] {DPR_IDLE, DPR_SETUP, DPR_PULSE, DPR_RECOVER} dpr_phase_e;
  typedef struct packed {
    logic [`DPR_ADDR_W-1:0] addr;
    logic [`DPR_DATA_W-1:0] data;
    logic [`DPR_BE_W-1:0] be;
    logic write;
    logic semaphore_select_n;
  } dpr_req_s;
  typedef struct packed {
    logic [`DPR_ADDR_W-1:0] addr;
    logic chipSelN;
    logic semSelN;
    logic writeNotRead;
    logic outEnN;
    logic [`DPR_BE_W-1:0] byteLaneSelN;
  } dpr_pins_s;
  typedef logic [`DPR_CNT_W-1:0] dpr_cnt_t;
endpackage

/* core/dpr_timer.sv */
// Down-counter that flags when a loaded cycle count has run out
`timescale 1ns/1ps
module dpr_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire dpr_pkg::dpr_cnt_t loadVal,
  output logic done
);
  dpr_pkg::dpr_cnt_t cnt_reg;
  dpr_pkg::dpr_cnt_t cnt_next;

  // Load wins, otherwise count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = loadVal;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Register the count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Done decodes the register only, so a load that depends on it forms no loop
  assign done = (cnt_reg == '0);
endmodule

/* core/dpr_host.sv */
// Host controller for one port of an asynchronous dual-port RAM
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_host (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reqValid,
  output logic reqReady,
  input wire dpr_pkg::dpr_req_s req,
  output logic rspValid,
  output logic [`DPR_DATA_W-1:0] rspData,
  output logic rspSemFlag,
  output logic rspBusyHit,
  output dpr_pkg::dpr_pins_s pins,
  input wire logic [`DPR_DATA_W-1:0] dataIn,
  output logic [`DPR_DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic busyN
);
  localparam dpr_pkg::dpr_cnt_t SETUP_CYC = dpr_pkg::dpr_cnt_t'(`DPR_HZ_CYC);
  localparam int PULSE_RAW = (`DPR_WZDW_CYC > `DPR_WP_CYC) ? `DPR_WZDW_CYC : `DPR_WP_CYC;
  localparam dpr_pkg::dpr_cnt_t PULSE_CYC = dpr_pkg::dpr_cnt_t'(PULSE_RAW);
  localparam dpr_pkg::dpr_cnt_t HOLD_CYC = dpr_pkg::dpr_cnt_t'(`DPR_WH_CYC);
  localparam dpr_pkg::dpr_cnt_t READ_CYC = dpr_pkg::dpr_cnt_t'(`DPR_RD_CYC);

  dpr_pkg::dpr_phase_e phase_reg;
  dpr_pkg::dpr_phase_e phase_next;
  dpr_pkg::dpr_req_s cur_reg;
  dpr_pkg::dpr_req_s cur_next;
  logic [`DPR_DATA_W-1:0] rd_reg;
  logic [`DPR_DATA_W-1:0] rd_next;
  logic hit_reg;
  logic hit_next;
  logic valid_reg;
  logic valid_next;
  logic timerLoad;
  dpr_pkg::dpr_cnt_t timerVal;
  logic timerDone;
  logic strobe;

  // Shared wait counter for every timed phase
  dpr_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .load(timerLoad),
    .loadVal(timerVal),
    .done(timerDone)
  );

  // Phase sequencing of one access
  always_comb begin
    phase_next = phase_reg;
    cur_next = cur_reg;
    rd_next = rd_reg;
    hit_next = hit_reg;
    valid_next = 1'b0;
    timerLoad = 1'b0;
    timerVal = SETUP_CYC;
    case (phase_reg)
      dpr_pkg::DPR_IDLE: begin
        if (reqValid) begin
          cur_next = req; // Address moves only here, all strobes high [R5]
          hit_next = 1'b0;
          phase_next = dpr_pkg::DPR_SETUP;
          timerLoad = 1'b1;
          timerVal = SETUP_CYC; // Let device drivers turn off first [R6]
        end
      end
      dpr_pkg::DPR_SETUP: begin
        if (timerDone) begin
          phase_next = dpr_pkg::DPR_PULSE;
          timerLoad = 1'b1;
          timerVal = cur_reg.write ? PULSE_CYC : READ_CYC; // Pulse width, read wait [R4] [R13] [R18]
        end
      end
      dpr_pkg::DPR_PULSE: begin
        if (!busyN) begin
          hit_next = 1'b1; // Lost arbitration, stretch the strobe [R15] [R17]
          timerLoad = 1'b1;
          timerVal = cur_reg.write ? HOLD_CYC : READ_CYC; // Restart after busy clears [R16] [R12]
        end else if (timerDone) begin
          rd_next = dataIn;
          valid_next = 1'b1;
          phase_next = dpr_pkg::DPR_RECOVER;
        end
      end
      dpr_pkg::DPR_RECOVER: begin
        phase_next = dpr_pkg::DPR_IDLE; // Write strobe high for one cycle while the selects stay low, then idle
      end
      default: begin
        phase_next = dpr_pkg::DPR_IDLE;
      end
    endcase
  end

  // Register the access state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_reg <= dpr_pkg::DPR_IDLE;
      cur_reg <= '0;
      rd_reg <= '0;
      hit_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cur_reg <= cur_next;
      rd_reg <= rd_next;
      hit_reg <= hit_next;
      valid_reg <= valid_next;
    end
  end

  // Pin drive: select before write, one select at a time
  assign strobe = (phase_reg == dpr_pkg::DPR_PULSE);
  always_comb begin
    pins.addr = cur_reg.addr;
    pins.chipSelN = !((phase_reg != dpr_pkg::DPR_IDLE) && !cur_reg.semaphore_select_n); // [R2]
    pins.semSelN = !((phase_reg != dpr_pkg::DPR_IDLE) && cur_reg.semaphore_select_n); // [R2]
    pins.writeNotRead = !(strobe && cur_reg.write); // Write pulse inside select [R1] [R3]
    pins.outEnN = !((phase_reg != dpr_pkg::DPR_IDLE) && !cur_reg.write); // [R14]
    pins.byteLaneSelN = (phase_reg != dpr_pkg::DPR_IDLE) ? ~cur_reg.be : '1;
  end

  // Drive data only in the write pulse, after the turnoff wait [R6]
  assign dataOe = strobe && cur_reg.write;
  assign dataOut = cur_reg.data;
  assign reqReady = (phase_reg == dpr_pkg::DPR_IDLE);
  assign rspValid = valid_reg;
  assign rspData = rd_reg;
  assign rspSemFlag = rd_reg[0]; // Flag repeats on every line [R7]
  assign rspBusyHit = hit_reg;

  // Never drive data while output enable is asserted
  property p_no_contention;
    @(posedge clk) disable iff (!rstn) dataOe |-> pins.outEnN;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("data driven with oe low"); // [R6]

  // Exactly one select while an access is active
  property p_one_select;
    @(posedge clk) disable iff (!rstn) (phase_reg != dpr_pkg::DPR_IDLE) |->
      (pins.chipSelN != pins.semSelN);
  endproperty
  a_one_select: assert property (p_one_select) else $error("bad select pair"); // [R2]

  // Address stable while write strobe low
  property p_addr_stable;
    @(posedge clk) disable iff (!rstn) (!pins.writeNotRead && !$past(pins.writeNotRead)) |->
      $stable(pins.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write"); // [R5]

  // Write strobe never starts before select
  property p_select_first;
    @(posedge clk) disable iff (!rstn) $fell(pins.writeNotRead) |->
      (!$past(pins.chipSelN) || !$past(pins.semSelN));
  endproperty
  a_select_first: assert property (p_select_first) else $error("write before select"); // [R3]

  // Write pulse lasts at least the widened width
  property p_pulse_width;
    @(posedge clk) disable iff (!rstn) $fell(pins.writeNotRead) |-> !pins.writeNotRead [*3];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("write pulse too short"); // [R4]

  // Busy low keeps the write strobe asserted
  property p_busy_hold;
    @(posedge clk) disable iff (!rstn) (!busyN && !pins.writeNotRead) |=> !pins.writeNotRead;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("write released under busy"); // [R15]

  // After busy releases, write held at least the hold time
  property p_hold_after_busy;
    @(posedge clk) disable iff (!rstn) ($rose(busyN) && !pins.writeNotRead) |->
      !pins.writeNotRead [*2];
  endproperty
  a_hold_after_busy: assert property (p_hold_after_busy) else $error("write hold short"); // [R16]

  // Read answer only after the full far-port delay
  property p_read_wait;
    @(posedge clk) disable iff (!rstn) ($rose(strobe) && !cur_reg.write) |-> !rspValid [*5];
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answered early"); // [R18]
endmodule

/* test/dpr_ram_model.sv */
// Behavioural model of one port of the dual-port RAM
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module dpr_ram_model (
  input wire logic clk,
  input wire dpr_pkg::dpr_pins_s pins,
  input wire logic [`DPR_DATA_W-1:0] lineIn,
  input wire logic busyN,
  output logic [`DPR_DATA_W-1:0] devData,
  output logic devOe
);
  logic [`DPR_DATA_W-1:0] mem [16];
  logic semFlag = 1'b1;
  int accCnt = 0;
  logic ramSel;
  logic semSel;
  logic wrAct;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = '0;
  end
  // Select decode and write qualification
  assign ramSel = !pins.chipSelN && pins.semSelN;
  assign semSel = pins.chipSelN && !pins.semSelN;
  assign wrAct = !pins.writeNotRead && busyN;
  // Drive only on a read with output enable, a select and a lane on
  assign devOe = pins.writeNotRead && !pins.outEnN && (ramSel || semSel)
    && (pins.byteLaneSelN != 4'hf);
  // Read data: flag on every line, or inverted data until access time passes
  always_comb begin
    if (semSel) devData = {`DPR_DATA_W{semFlag}};
    else if (accCnt < 2) devData = ~mem[pins.addr[3:0]];
    else devData = mem[pins.addr[3:0]];
  end
  // Store enabled lanes or the flag while the write is active
  always @(posedge clk) begin
    accCnt <= devOe ? accCnt + 1 : 0;
    if (wrAct && semSel) semFlag <= lineIn[0]; // One flag, one owner per write
    for (int i = 0; i < `DPR_BE_W; i++) begin
      if (wrAct && ramSel && !pins.byteLaneSelN[i]) mem[pins.addr[3:0]][i*9 +: 9] <= lineIn[i*9 +: 9];
    end
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the dual-port RAM host controller
`timescale 1ns/1ps
`include "dpr_cfg.svh"
module tb_top;
  logic clk = 0;
  logic rstn = 0;
  logic reqValid = 0;
  logic busyN = 1;
  dpr_pkg::dpr_req_s req = '0;
  dpr_pkg::dpr_pins_s pins;
  logic reqReady, rspValid, rspSemFlag, rspBusyHit, dataOe, devOe, prevLow = 0;
  logic [`DPR_DATA_W-1:0] rspData, dataOut, devData, busLine, lastLine = '0;
  logic [`DPR_ADDR_W-1:0] prevAddr;
  int err_total = 0, checked = 0, lowCnt = 0, holdCnt = 0, lastPulse = 0, lastHold = 0;
  always #2.5 clk = ~clk;
  // Shared data line; undriven it shows the inverse of its last level
  assign busLine = dataOe ? dataOut : (devOe ? devData : ~lastLine);
  dpr_host u_dpr_host (.clk(clk), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rspValid(rspValid), .rspData(rspData), .rspSemFlag(rspSemFlag),
    .rspBusyHit(rspBusyHit), .pins(pins), .dataIn(busLine), .dataOut(dataOut),
    .dataOe(dataOe), .busyN(busyN));
  dpr_ram_model u_dpr_ram_model (.clk(clk), .pins(pins), .lineIn(busLine), .busyN(busyN),
    .devData(devData), .devOe(devOe));
  task automatic check(input logic [`DPR_DATA_W-1:0] got, input logic [`DPR_DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One access through the request handshake, bounded waits
  task automatic access(input logic wr, input logic semaphore_select_n, input logic [16:0] a,
    input logic [35:0] d, input logic [3:0] be);
    int n;
    req = '{addr: a, data: d, be: be, write: wr, semaphore_select_n: semaphore_select_n};
    reqValid = 1;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    reqValid = 0;
    while (rspValid !== 1'b1 && n < 150) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rspValid !== 1'b1) begin
      err_total++;
      final_report();
    end
  endtask
  // Pin monitor: strobe lengths, select exclusion, bus sharing, address hold
  always @(posedge clk) begin
    lastLine <= busLine;
    prevAddr <= pins.addr;
    prevLow <= !pins.writeNotRead;
    lowCnt <= pins.writeNotRead ? 0 : lowCnt + 1;
    holdCnt <= (pins.writeNotRead || !busyN) ? 0 : holdCnt + 1;
    if (pins.writeNotRead && prevLow) begin
      lastPulse <= lowCnt;
      lastHold <= holdCnt;
    end
    if (rstn) begin
      check(36'(dataOe && devOe), '0);
      check(36'(!pins.chipSelN && !pins.semSelN), '0);
    end
    if (!pins.writeNotRead && prevLow) check(36'(pins.addr), 36'(prevAddr));
  end
  task automatic t_ram;
    access(1, 0, 5, 36'h9a5c3e712, 4'hf);
    access(0, 0, 5, '0, 4'hf);
    check(rspData, 36'h9a5c3e712);
    check(36'(rspBusyHit), '0);
    check(36'(lastPulse >= `DPR_WZDW_CYC), 36'h1);
    $display("t_ram done");
  endtask
  task automatic t_lanes;
    access(1, 0, 6, 36'hfffffffff, 4'hf);
    access(1, 0, 6, '0, 4'h2);
    access(0, 0, 6, '0, 4'hf);
    check(rspData, 36'hffffc01ff);
    $display("t_lanes done");
  endtask
  task automatic t_sem;
    for (int v = 0; v < 2; v++) begin
      access(1, 1, 0, 36'(v), 4'hf);
      access(0, 1, 0, '0, 4'hf);
      check(rspData, {36{v[0]}});
      check(36'(rspSemFlag), 36'(v));
    end
    $display("t_sem done");
  endtask
  // Opposite port matches first: busy low from select, before and into the write pulse
  task automatic t_busy;
    int n;
    n = 0;
    fork
      access(1, 0, 7, 36'h123456789, 4'hf);
      begin
        // Conflict only on select low and address match, busy on this port alone
        while ((pins.chipSelN !== 1'b0 || pins.addr !== 17'h7) && n < 50) begin
          @(posedge clk);
          #1;
          n++;
        end
        check(36'(pins.chipSelN), '0);
        busyN = 0; // Asserted before the write starts
        repeat (4) @(posedge clk);
        #1;
        busyN = 1;
      end
    join
    check(36'(rspBusyHit), 36'h1);
    access(0, 0, 7, '0, 4'hf);
    check(rspData, 36'h123456789);
    check(36'(lastHold >= `DPR_WH_CYC), 36'h1);
    $display("t_busy done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rstn = 1;
    @(posedge clk);
    #1;
    t_ram();
    t_lanes();
    t_sem();
    t_busy();
    final_report();
  end
endmodule
